// file: logic/pad_cfg_pkg.sv
// constants for the serial and test pad configuration block
// Contract
// R1: port E line 0 is serial0 tx; bit0 pull-up
// R2: port E line 1 is serial0 rx; bit1 pull-up
// R3: port D line 6 is serial1 tx; bit6 pull-up
// R4: port D line 7 is serial1 rx; bit7 pull-up
// R5: in reset tx off, all pull-ups on
// R6: port D lines 0,1 default general-purpose
// R7: software should set bus drive bit
// R8: test mode select sampled on test clock rise
// R9: test data in sampled on test clock rise
// R10: test-port disable bit removes test pull-ups
// R11: test clock pulled low, mode/data high
// R12: test data out driven only in shifts
// R13: drive bit tri-states idle bus outputs; code releases them only while the bit is clear
// R14: pull-up control bits reset enabled
package pad_cfg_pkg;
  localparam int PORT_W = 16;
  localparam logic [15:0] PULLUP_RST = 16'hffff;
  localparam int BIT_E_TX0 = 0;
  localparam int BIT_E_RX0 = 1;
  localparam int BIT_D_TX1 = 6;
  localparam int BIT_D_RX1 = 7;
  localparam int BIT_D_CS2 = 0;
  localparam int BIT_D_CS3 = 1;
  localparam logic DRIVE_RST = 1'b0;
  localparam logic TEST_PUD_RST = 1'b0;
  localparam logic FUNC_PERIPH_RST = 1'b1;
  localparam logic FUNC_GPIO_RST = 1'b0;
endpackage

// file: logic/pin_sync.sv
// three-stage synchroniser with agreement filter
module pin_sync (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic rstVal,
  input wire logic pinIn,
  output logic pinOut
);
  logic s1_ff, s2_ff, s3_ff, out_ff;
  logic nxt_out, flip;
  // flops hold the pin xor flip, so constant resets give the idle level rstVal
  assign flip = ~rstVal;
  assign nxt_out = (s2_ff == s3_ff) ? s3_ff : out_ff;
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      s1_ff <= 1'b1;
      s2_ff <= 1'b1;
      s3_ff <= 1'b1;
      out_ff <= 1'b1;
    end else begin
      s1_ff <= pinIn ^ flip;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      out_ff <= nxt_out;
    end
  end
  assign pinOut = out_ff ^ flip;
endmodule

// file: logic/serial_and_test_pad_config.sv
// pad function, pull-up and test-pin logic for serial, chip-select and test pins
module serial_and_test_pad_config
  import pad_cfg_pkg::*;
#(
  parameter int PW = PORT_W
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic [PW-1:0] portDPullupWr,
  input wire logic [PW-1:0] portDPullupData,
  input wire logic [PW-1:0] portEPullupWr,
  input wire logic [PW-1:0] portEPullupData,
  input wire logic sysPudWr,
  input wire logic sysPudData,
  input wire logic busDriveWr,
  input wire logic busDriveData,
  input wire logic funcWr,
  input wire logic [3:0] funcData,
  input wire logic serial0TxData,
  input wire logic serial1TxData,
  input wire logic [3:0] gpioOut,
  input wire logic [3:0] gpioOe,
  input wire logic busIdle,
  input wire logic [1:0] csOut,
  input wire logic [1:0] csGpioOut,
  input wire logic [1:0] csGpioOe,
  input wire logic [3:0] serialPinIn,
  input wire logic testClkPin,
  input wire logic testModePin,
  input wire logic testDataPin,
  input wire logic shiftState,
  input wire logic testDataOutBit,
  output logic [PW-1:0] portDPullup,
  output logic [PW-1:0] portEPullup,
  output logic testPortPudOut,
  output logic busDriveOut,
  output logic [3:0] serialPinOut,
  output logic [3:0] serialPinOe,
  output logic [3:0] serialPullupEn,
  output logic [1:0] csPinOut,
  output logic [1:0] csPinOe,
  output logic [1:0] csPullupEn,
  output logic busCtrlOe,
  output logic serial0RxData,
  output logic serial1RxData,
  output logic [3:0] gpioIn,
  output logic testModeSample,
  output logic testDataSample,
  output logic testSampleStrobe,
  output logic testModePullupEn,
  output logic testDataPullupEn,
  output logic testClkPulldownEn,
  output logic testDataOut,
  output logic testDataOe
);
  // serial pin order: 0 tx0 (E0), 1 rx0 (E1), 2 tx1 (D6), 3 rx1 (D7)
  logic [PW-1:0] portDPull_ff, portEPull_ff;
  logic sysPud_ff, drive_ff;
  logic [3:0] periph_ff;
  logic inReset_ff;
  logic [3:0] serOut_ff, serOe_ff, serPull_ff;
  logic [1:0] csOut_ff, csOe_ff, csPull_ff;
  logic busOe_ff, rx0_ff, rx1_ff;
  logic [3:0] gpioIn_ff;
  logic tmsS_ff, tdiS_ff, strobe_ff, tckPrev_ff, tdo_ff, tdoOe_ff;
  logic [3:0] serSync;
  logic tckSync, tmsSync, tdiSync;
  logic [PW-1:0] nxt_portDPull, nxt_portEPull;
  logic [3:0] nxt_serOut, nxt_serOe, nxt_serPull, pinPull;
  logic [1:0] nxt_csOut, nxt_csOe, nxt_csPull;
  logic tckRise, tckFall, nxt_busOe;
  logic nxt_sysPud, tmsPu_ff, tdiPu_ff, tckPd_ff;

  // pull-up registers with per-bit writes, reset to enabled
  assign nxt_portDPull = (portDPull_ff & ~portDPullupWr) | (portDPullupData & portDPullupWr);
  assign nxt_portEPull = (portEPull_ff & ~portEPullupWr) | (portEPullupData & portEPullupWr);
  assign nxt_sysPud = sysPudWr ? sysPudData : sysPud_ff;
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      portDPull_ff <= PULLUP_RST; // [R14]
      portEPull_ff <= PULLUP_RST; // [R14]
      sysPud_ff <= TEST_PUD_RST;
      tmsPu_ff <= 1'b1; // [R11]
      tdiPu_ff <= 1'b1; // [R11]
      tckPd_ff <= 1'b1; // [R11]
      drive_ff <= DRIVE_RST; // [R7]
      periph_ff <= {4{FUNC_PERIPH_RST}}; // [R1] [R2] [R3] [R4]
      inReset_ff <= 1'b1;
    end else begin
      portDPull_ff <= nxt_portDPull;
      portEPull_ff <= nxt_portEPull;
      sysPud_ff <= nxt_sysPud;
      tmsPu_ff <= ~nxt_sysPud; // [R10]
      tdiPu_ff <= ~nxt_sysPud; // [R10]
      tckPd_ff <= 1'b1; // [R11]
      drive_ff <= busDriveWr ? busDriveData : drive_ff;
      periph_ff <= funcWr ? funcData : periph_ff;
      inReset_ff <= 1'b0;
    end
  end

  // per-pin pull-up bit selection
  assign pinPull[0] = portEPull_ff[BIT_E_TX0]; // [R1]
  assign pinPull[1] = portEPull_ff[BIT_E_RX0]; // [R2]
  assign pinPull[2] = portDPull_ff[BIT_D_TX1]; // [R3]
  assign pinPull[3] = portDPull_ff[BIT_D_RX1]; // [R4]

  // serial pins: peripheral or gpio function
  assign nxt_serOut[0] = periph_ff[0] ? serial0TxData : gpioOut[0]; // [R1]
  assign nxt_serOe[0] = periph_ff[0] ? 1'b1 : gpioOe[0]; // [R1]
  assign nxt_serOut[1] = gpioOut[1];
  assign nxt_serOe[1] = periph_ff[1] ? 1'b0 : gpioOe[1]; // [R2]
  assign nxt_serOut[2] = periph_ff[2] ? serial1TxData : gpioOut[2]; // [R3]
  assign nxt_serOe[2] = periph_ff[2] ? 1'b1 : gpioOe[2]; // [R3]
  assign nxt_serOut[3] = gpioOut[3];
  assign nxt_serOe[3] = periph_ff[3] ? 1'b0 : gpioOe[3]; // [R4]
  assign nxt_serPull = pinPull & ~nxt_serOe;

  // chip-select pins: always gpio, the external bus input csOut is not used
  assign nxt_csOut = csGpioOut;
  assign nxt_csOe = csGpioOe; // [R6]
  assign nxt_csPull[0] = portDPull_ff[BIT_D_CS2] & ~csGpioOe[0]; // [R6]
  assign nxt_csPull[1] = portDPull_ff[BIT_D_CS3] & ~csGpioOe[1]; // [R6]
  assign nxt_busOe = ~(drive_ff == 1'b0 && busIdle); // [R13]

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      serOut_ff <= 4'h0;
      serOe_ff <= 4'h0; // [R5]
      serPull_ff <= 4'hf; // [R5]
      csOut_ff <= 2'h0;
      csOe_ff <= 2'h0;
      csPull_ff <= 2'h3;
      busOe_ff <= 1'b0;
      rx0_ff <= 1'b1;
      rx1_ff <= 1'b1;
      gpioIn_ff <= 4'hf;
    end else begin
      serOut_ff <= nxt_serOut;
      serOe_ff <= inReset_ff ? 4'h0 : nxt_serOe;
      serPull_ff <= inReset_ff ? 4'hf : nxt_serPull;
      csOut_ff <= nxt_csOut;
      csOe_ff <= nxt_csOe;
      csPull_ff <= nxt_csPull;
      busOe_ff <= nxt_busOe;
      rx0_ff <= periph_ff[1] ? serSync[1] : 1'b1; // [R2]
      rx1_ff <= periph_ff[3] ? serSync[3] : 1'b1; // [R4]
      gpioIn_ff <= serSync;
    end
  end

  // synchronisers for pad inputs
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_ser
      pin_sync u_sync (
        .mclk(mclk),
        .rstn(rstn),
        .rstVal(1'b1),
        .pinIn(serialPinIn[gi]),
        .pinOut(serSync[gi])
      );
    end
  endgenerate
  pin_sync u_tck (.mclk(mclk), .rstn(rstn), .rstVal(1'b0), .pinIn(testClkPin),
    .pinOut(tckSync));
  pin_sync u_tms (.mclk(mclk), .rstn(rstn), .rstVal(1'b1), .pinIn(testModePin),
    .pinOut(tmsSync));
  pin_sync u_tdi (.mclk(mclk), .rstn(rstn), .rstVal(1'b1), .pinIn(testDataPin),
    .pinOut(tdiSync));

  // test clock edges and sampling
  assign tckRise = tckSync & ~tckPrev_ff;
  assign tckFall = ~tckSync & tckPrev_ff;
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      tckPrev_ff <= 1'b0;
      tmsS_ff <= 1'b1;
      tdiS_ff <= 1'b1;
      strobe_ff <= 1'b0;
      tdo_ff <= 1'b0;
      tdoOe_ff <= 1'b0;
    end else begin
      tckPrev_ff <= tckSync;
      strobe_ff <= tckRise; // [R8]
      if (tckRise) begin
        tmsS_ff <= tmsSync; // [R8]
        tdiS_ff <= tdiSync; // [R9]
      end
      if (tckFall) begin
        tdo_ff <= testDataOutBit; // [R12]
        tdoOe_ff <= shiftState; // [R12]
      end
    end
  end

  assign portDPullup = portDPull_ff;
  assign portEPullup = portEPull_ff;
  assign testPortPudOut = sysPud_ff;
  assign busDriveOut = drive_ff;
  assign serialPinOut = serOut_ff;
  assign serialPinOe = serOe_ff;
  assign serialPullupEn = serPull_ff;
  assign csPinOut = csOut_ff;
  assign csPinOe = csOe_ff;
  assign csPullupEn = csPull_ff;
  assign busCtrlOe = busOe_ff;
  assign serial0RxData = rx0_ff;
  assign serial1RxData = rx1_ff;
  assign gpioIn = gpioIn_ff;
  assign testModeSample = tmsS_ff;
  assign testDataSample = tdiS_ff;
  assign testSampleStrobe = strobe_ff;
  assign testModePullupEn = tmsPu_ff; // [R10] [R11]
  assign testDataPullupEn = tdiPu_ff; // [R10] [R11]
  assign testClkPulldownEn = tckPd_ff; // [R11]
  assign testDataOut = tdo_ff;
  assign testDataOe = tdoOe_ff;

  a_reset_defaults: assert property (@(posedge mclk) $rose(rstn) |-> // [R14]
    portDPull_ff == PULLUP_RST && portEPull_ff == PULLUP_RST)
    else $error("pull-up controls not enabled after reset");
  a_tx_off_reset: assert property (@(posedge mclk) disable iff (!rstn) // [R5]
    inReset_ff |=> serOe_ff == 4'h0 && serPull_ff == 4'hf)
    else $error("serial pins not quiet during reset");
  a_tx0_pullup: assert property (@(posedge mclk) disable iff (!rstn) // [R1]
    !inReset_ff && !portEPull_ff[BIT_E_TX0] |=> !serPull_ff[0])
    else $error("tx0 pull-up not removed");
  a_rx0_pullup: assert property (@(posedge mclk) disable iff (!rstn) // [R2]
    !inReset_ff && !portEPull_ff[BIT_E_RX0] |=> !serPull_ff[1])
    else $error("rx0 pull-up not removed");
  a_tx1_drive: assert property (@(posedge mclk) disable iff (!rstn) // [R3]
    !inReset_ff && periph_ff[2] |=> serOe_ff[2] && serOut_ff[2] == $past(serial1TxData))
    else $error("tx1 not driven from serial channel");
  a_rx1_pullup: assert property (@(posedge mclk) disable iff (!rstn) // [R4]
    !portDPull_ff[BIT_D_RX1] |=> !serPull_ff[3])
    else $error("rx1 pull-up not removed");
  a_cs_gpio: assert property (@(posedge mclk) disable iff (!rstn) // [R6]
    !portDPull_ff[BIT_D_CS2] |=> !csPull_ff[0])
    else $error("chip-select pull-up not removed");
  a_tms_sample: assert property (@(posedge mclk) disable iff (!rstn) // [R8]
    tckRise |=> strobe_ff && tmsS_ff == $past(tmsSync))
    else $error("mode select not sampled on test clock rise");
  a_tdi_sample: assert property (@(posedge mclk) disable iff (!rstn) // [R9]
    tckRise |=> tdiS_ff == $past(tdiSync))
    else $error("test data not sampled on test clock rise");
  a_test_pud: assert property (@(posedge mclk) disable iff (!rstn) // [R10]
    sysPudWr && sysPudData |=> !testModePullupEn && !testDataPullupEn)
    else $error("test pull-ups not removed");
  a_tdo_enable: assert property (@(posedge mclk) disable iff (!rstn) // [R12]
    tckFall && !shiftState |=> !tdoOe_ff)
    else $error("test data out driven outside shift");
  a_bus_idle: assert property (@(posedge mclk) disable iff (!rstn) // [R13]
    !drive_ff && busIdle |=> !busOe_ff)
    else $error("idle bus not released");

  // test clock steps: edge seen after sync, then strobe with fresh samples
  sequence s_tck_rise;
    tckSync && !tckPrev_ff;
  endsequence
  sequence s_sample_loaded;
    strobe_ff && tmsS_ff == $past(tmsSync) && tdiS_ff == $past(tdiSync);
  endsequence
  sequence s_tck_fall;
    !tckSync && tckPrev_ff;
  endsequence

  a_sample_steps: assert property (@(posedge mclk) disable iff (!rstn) // [R8] [R9]
    s_tck_rise |=> s_sample_loaded)
    else $error("test pins not loaded after test clock rise");
  a_strobe_pulse: assert property (@(posedge mclk) disable iff (!rstn) // [R8]
    strobe_ff |=> !strobe_ff)
    else $error("sample strobe longer than one cycle");
  a_tdo_launch: assert property (@(posedge mclk) disable iff (!rstn) // [R12]
    s_tck_fall ##0 shiftState |=> tdoOe_ff && tdo_ff == $past(testDataOutBit))
    else $error("test data out not launched on test clock fall");
  a_tx0_drive: assert property (@(posedge mclk) disable iff (!rstn) // [R1]
    !inReset_ff && periph_ff[0] |=> serOe_ff[0] && serOut_ff[0] == $past(serial0TxData))
    else $error("tx0 not driven from serial channel");
  a_rx0_data: assert property (@(posedge mclk) disable iff (!rstn) // [R2]
    periph_ff[1] |=> rx0_ff == $past(serSync[1]))
    else $error("rx0 data not passed to serial channel");
  a_rx0_idle: assert property (@(posedge mclk) disable iff (!rstn) // [R2]
    !periph_ff[1] |=> rx0_ff)
    else $error("rx0 data not idle in gpio use");
  a_tx1_pullup: assert property (@(posedge mclk) disable iff (!rstn) // [R3]
    !inReset_ff && !portDPull_ff[BIT_D_TX1] |=> !serPull_ff[2])
    else $error("tx1 pull-up not removed");
  a_rx1_data: assert property (@(posedge mclk) disable iff (!rstn) // [R4]
    periph_ff[3] |=> rx1_ff == $past(serSync[3]))
    else $error("rx1 data not passed to serial channel");
  a_rx1_idle: assert property (@(posedge mclk) disable iff (!rstn) // [R4]
    !periph_ff[3] |=> rx1_ff)
    else $error("rx1 data not idle in gpio use");
  a_cs_oe: assert property (@(posedge mclk) disable iff (!rstn) // [R6]
    1'b1 |=> csOe_ff == $past(csGpioOe))
    else $error("chip-select pins not under gpio control");
  a_cs3_pullup: assert property (@(posedge mclk) disable iff (!rstn) // [R6]
    !portDPull_ff[BIT_D_CS3] |=> !csPull_ff[1])
    else $error("second chip-select pull-up not removed");
  a_bus_driven: assert property (@(posedge mclk) disable iff (!rstn) // [R13]
    drive_ff |=> busOe_ff)
    else $error("bus outputs released while drive bit set");
  a_test_pullups: assert property (@(posedge mclk) disable iff (!rstn) // [R10] [R11]
    tmsPu_ff == !sysPud_ff && tdiPu_ff == !sysPud_ff)
    else $error("test pull-ups disagree with disable bit");
  a_gpio_in: assert property (@(posedge mclk) disable iff (!rstn) // [R2] [R4]
    1'b1 |=> gpioIn_ff == $past(serSync))
    else $error("gpio inputs not following pads");
endmodule

// file: verification/serial_test_host.sv
// serial peer and boundary-scan host model driving the pad inputs
module serial_test_host (
  output logic [3:0] serialPinIn,
  output logic testClkPin,
  output logic testModePin,
  output logic testDataPin
);
  timeunit 1ns;
  timeprecision 1ps;
  logic rx0 = 1'b1;
  logic rx1 = 1'b1;
  // tx pads are not driven by the peer, the pull-up holds them high
  assign serialPinIn = {rx1, 1'b1, rx0, 1'b1};
  // test clock stands low between bits
  initial begin
    testClkPin = 1'b0;
    testModePin = 1'b1;
    testDataPin = 1'b1;
  end
  task automatic set_rx(input logic a, input logic b);
    rx0 = a;
    rx1 = b;
  endtask
  // mode and data settle well ahead of the test clock rise
  task automatic send_bit(input logic m, input logic d);
    testModePin = m;
    testDataPin = d;
    #50;
    testClkPin = 1'b1;
    #80;
    testClkPin = 1'b0;
    #80;
  endtask
endmodule

// file: verification/testbench.sv
// self-checking bench for the serial and test pad configuration block
`define CHK(nm, exp, got) begin tests_run++; if ((got) !== (exp)) begin errors++; \
  $display("wrong value %s expected %h seen %h", nm, exp, got); end end
module testbench;
  import pad_cfg_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 1'b0;
  logic rstn = 1'b0;
  logic [15:0] portDPullupWr = 16'h0000, portDPullupData = 16'h0000;
  logic [15:0] portEPullupWr = 16'h0000, portEPullupData = 16'h0000;
  logic sysPudWr = 1'b0, sysPudData = 1'b0, busDriveWr = 1'b0, busDriveData = 1'b0;
  logic funcWr = 1'b0, serial0TxData = 1'b0, serial1TxData = 1'b0, busIdle = 1'b0;
  logic shiftState = 1'b0, testDataOutBit = 1'b0;
  logic [3:0] funcData = 4'hf, gpioOut = 4'h0, gpioOe = 4'h0;
  logic [1:0] csOut = 2'h0, csGpioOut = 2'h0, csGpioOe = 2'h0;
  logic [3:0] serialPinIn, serialPinOut, serialPinOe, serialPullupEn, gpioIn;
  logic testClkPin, testModePin, testDataPin, gotM, gotD, r0, r1;
  logic [15:0] portDPullup, portEPullup, w1, d1, w2, d2;
  logic [15:0] expD = 16'hffff, expE = 16'hffff;
  logic [1:0] csPinOut, csPinOe, csPullupEn;
  logic testPortPudOut, busDriveOut, busCtrlOe, serial0RxData, serial1RxData;
  logic testModeSample, testDataSample, testSampleStrobe, testModePullupEn;
  logic testDataPullupEn, testClkPulldownEn, testDataOut, testDataOe;
  int errors = 0, tests_run = 0, strobes = 0, n;

  always #4 mclk = ~mclk;

  serial_and_test_pad_config DUT (.mclk, .rstn, .portDPullupWr, .portDPullupData,
    .portEPullupWr, .portEPullupData, .sysPudWr, .sysPudData, .busDriveWr, .busDriveData,
    .funcWr, .funcData, .serial0TxData, .serial1TxData, .gpioOut, .gpioOe, .busIdle,
    .csOut, .csGpioOut, .csGpioOe, .serialPinIn, .testClkPin, .testModePin, .testDataPin,
    .shiftState, .testDataOutBit, .portDPullup, .portEPullup, .testPortPudOut, .busDriveOut,
    .serialPinOut, .serialPinOe, .serialPullupEn, .csPinOut, .csPinOe, .csPullupEn,
    .busCtrlOe, .serial0RxData, .serial1RxData, .gpioIn, .testModeSample, .testDataSample,
    .testSampleStrobe, .testModePullupEn, .testDataPullupEn, .testClkPulldownEn,
    .testDataOut, .testDataOe);
  serial_test_host host (.serialPinIn, .testClkPin, .testModePin, .testDataPin);

  // capture each sample strobe and count them
  always @(negedge mclk) begin
    if (testSampleStrobe === 1'b1) begin
      gotM <= testModeSample;
      gotD <= testDataSample;
      strobes <= strobes + 1;
    end
  end

  function automatic logic [15:0] merge(input logic [15:0] old, wr, dat);
    return (old & ~wr) | (dat & wr);
  endfunction

  task automatic tick(input int k);
    repeat (k) @(negedge mclk);
  endtask

  task automatic pu_write(input logic [15:0] dw, dd, ew, ed);
    portDPullupWr = dw;
    portDPullupData = dd;
    portEPullupWr = ew;
    portEPullupData = ed;
    tick(1);
    portDPullupWr = 16'h0000;
    portEPullupWr = 16'h0000;
    tick(2);
  endtask

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  initial begin
    #200000;
    errors++;
    tally_and_finish();
  end

  initial begin
    n = $urandom(46);
    tick(11);
    `CHK("port d pull-ups", PULLUP_RST, portDPullup)
    `CHK("port e pull-ups", PULLUP_RST, portEPullup)
    `CHK("serial oe", 4'h0, serialPinOe)
    `CHK("serial pull-ups", 4'hf, serialPullupEn)
    `CHK("cs oe", 2'h0, csPinOe)
    `CHK("tdo oe", 1'b0, testDataOe)
    `CHK("tck pull-down", 1'b1, testClkPulldownEn)
    `CHK("tms pull-up", 1'b1, testModePullupEn)
    `CHK("tdi pull-up", 1'b1, testDataPullupEn)
    `CHK("bus drive", DRIVE_RST, busDriveOut)
    `CHK("reset bus oe", 1'b0, busCtrlOe)
    rstn = 1'b1;
    tick(3);
    for (int i = 0; i < 6; i++) begin
      {serial0TxData, serial1TxData, r0, r1} = 4'($urandom);
      host.set_rx(r0, r1);
      tick(8);
      `CHK("tx0 oe", 1'b1, serialPinOe[0])
      `CHK("tx0 pin", serial0TxData, serialPinOut[0])
      `CHK("rx0 oe", 1'b0, serialPinOe[1])
      `CHK("rx0 data", r0, serial0RxData)
      `CHK("tx1 oe", 1'b1, serialPinOe[2])
      `CHK("tx1 pin", serial1TxData, serialPinOut[2])
      `CHK("rx1 oe", 1'b0, serialPinOe[3])
      `CHK("rx1 data", r1, serial1RxData)
    end
    for (int i = 0; i < 10; i++) begin
      w1 = (i == 0) ? 16'hffff : 16'($urandom);
      d1 = (i == 0) ? 16'h0000 : 16'($urandom);
      w2 = (i == 0) ? 16'hffff : 16'($urandom);
      d2 = (i == 0) ? 16'h0000 : 16'($urandom);
      pu_write(w1, d1, w2, d2);
      expD = merge(expD, w1, d1);
      expE = merge(expE, w2, d2);
      `CHK("port d pull-ups", expD, portDPullup)
      `CHK("port e pull-ups", expE, portEPullup)
      `CHK("rx0 pull-up", expE[1], serialPullupEn[1])
      `CHK("rx1 pull-up", expD[7], serialPullupEn[3])
      `CHK("cs pull-ups", expD[1:0], csPullupEn)
    end
    funcData = 4'h0;
    funcWr = 1'b1;
    tick(1);
    funcWr = 1'b0;
    gpioOe = 4'hf;
    gpioOut = 4'($urandom);
    csGpioOe = 2'h3;
    csGpioOut = 2'($urandom);
    tick(3);
    `CHK("gpio pins", gpioOut, serialPinOut)
    `CHK("gpio oe", 4'hf, serialPinOe)
    `CHK("cs pins", csGpioOut, csPinOut)
    `CHK("cs oe", 2'h3, csPinOe)
    `CHK("gpio in", serialPinIn, gpioIn)
    `CHK("rx0 idle", 1'b1, serial0RxData)
    `CHK("rx1 idle", 1'b1, serial1RxData)
    gpioOe = 4'h0;
    tick(3);
    `CHK("idle pull-ups", {expD[7:6], expE[1:0]}, serialPullupEn)
    busIdle = 1'b1;
    tick(2);
    `CHK("idle bus oe", 1'b0, busCtrlOe)
    busDriveData = 1'b1;
    busDriveWr = 1'b1;
    tick(1);
    busDriveWr = 1'b0;
    tick(3);
    `CHK("bus drive", 1'b1, busDriveOut)
    `CHK("driven bus oe", 1'b1, busCtrlOe)
    sysPudData = 1'b1;
    sysPudWr = 1'b1;
    tick(1);
    sysPudWr = 1'b0;
    tick(2);
    `CHK("tms pull-up", 1'b0, testModePullupEn)
    `CHK("tdi pull-up", 1'b0, testDataPullupEn)
    `CHK("test pud bit", 1'b1, testPortPudOut)
    for (int i = 0; i < 8; i++) begin
      {r0, r1} = (i < 4) ? 2'(i) : 2'($urandom);
      shiftState = r0 ^ r1;
      testDataOutBit = 1'($urandom);
      n = strobes;
      host.send_bit(r0, r1);
      tick(1);
      `CHK("strobes", n + 1, strobes)
      `CHK("mode sample", r0, gotM)
      `CHK("data sample", r1, gotD)
      `CHK("tdo oe", shiftState, testDataOe)
      if (shiftState) `CHK("tdo", testDataOutBit, testDataOut)
    end
    n = strobes;
    rstn = 1'b0;
    tick(2);
    `CHK("port e pull-ups", PULLUP_RST, portEPullup)
    `CHK("serial oe", 4'h0, serialPinOe)
    `CHK("serial pull-ups", 4'hf, serialPullupEn)
    rstn = 1'b1;
    tick(4);
    `CHK("strobes", n, strobes)
    `CHK("tx0 oe", 1'b1, serialPinOe[0])
    tally_and_finish();
  end
endmodule
